// ===== hw/cfc_converter.sv
// channel format converter: decode, widen, narrow and scale pixel channels
// How it works
// - unsigned channel of n bits spans zero to two^n minus one
// - unsigned copy passes integer through, zero-extended to destination width
// - unsigned scaled gives equal float value, 32-bit sources rounded nearest even
// - signed channel of n bits is two's complement
// - signed copy passes integer through, sign-extended to destination width
// - signed scaled gives equal float, 0xFFFD is -3.0, nearest even rounding
// - float32 all-ones exponent: nonzero fraction NaN, zero fraction signed infinity
// - float32 layout sign 31, exponent 30:23, fraction 22:0, bias 127
// - float64 layout sign 63, exponent 62:52, fraction 51:0, bias 1023
// - float16 layout sign 15, exponent 14:10, fraction 9:0, bias 15
// - float32 narrowed to float16 rounds to nearest even
// - float11 unsigned, exponent 10:6, fraction 5:0, bias 15
// - float10 unsigned, exponent 9:5, fraction 4:0, bias 15
// - common exponent 31:27, blue 26:18, green 17:9, red 8:0, 0.f times 2^(e-15)
// - common exponent format yields only positive values or zero
// - pixel bits assembled little-endian from byte n upward
// - channel fields placed from least significant end in naming order
// - intensity value copied into all four channels
// - intensity as destination format is refused and flagged unsupported
`timescale 1ns/100ps
module cfc_converter
   import cfc_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire cfc_in_t IN_DATA,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output cfc_out_t OUT_DATA
);

   // integer to float32, round to nearest even
   function automatic logic [31:0] int_to_f32(input logic [31:0] mag, input logic neg);
      logic [31:0] norm = 32'h0;
      logic [4:0] msb = 5'h0;
      logic [30:0] body = 31'h0;
      logic up = 1'b0;
      if (mag == 32'h0)
         return 32'h0;
      for (int i = 0; i < 32; i++)
         if (mag[i])
            msb = 5'(i);
      norm = mag << (5'd31 - msb);
      up = norm[7] & ((|norm[6:0]) | norm[8]);
      body = {F32_BIAS + {3'h0, msb}, norm[30:8]};
      body = body + {30'h0, up};
      return {neg, body};
   endfunction

   // 5-bit-exponent float with sign bit s widened to float32; frac left aligned to 10 bits
   function automatic logic [31:0] small_to_f32(input logic s, input logic [4:0] e, input logic [9:0] f);
      logic [31:0] t;
      t = 32'h0;
      if (e == SMALL_EXP_MAX)
      begin
         if (f != 10'h0)
            return F32_CANON_NAN;
         return {s, F32_EXP_MAX, 23'h0};
      end
      if (e == 5'h0)
      begin
         if (f == 10'h0)
            return {s, 31'h0};
         // denormal: f times 2^-24, exact in float32
         t = int_to_f32({22'h0, f}, 1'b0);
         return {s, t[30:23] - SMALL_DENORM_ADJ, t[22:0]};
      end
      return {s, {3'h0, e} + SMALL_TO_F32_BIAS, f, 13'h0};
   endfunction

   // float32 narrowed to float16, round to nearest even
   function automatic logic [15:0] f32_to_f16(input logic [31:0] x);
      logic s;
      logic [7:0] e;
      logic [22:0] f;
      logic [7:0] shift = 8'h0;
      logic [49:0] wide = 50'h0;
      logic [15:0] r = 16'h0;
      logic up = 1'b0;
      s = x[31];
      e = x[30:23];
      f = x[22:0];
      if (e == F32_EXP_MAX)
         return (f != 23'h0) ? F16_CANON_NAN : {s, SMALL_EXP_MAX, 10'h0};
      if (e > F16_MAX_UNBIASED)
         return {s, SMALL_EXP_MAX, 10'h0};
      if (e >= F16_MIN_NORMAL_F32_EXP)
      begin
         up = f[12] & ((|f[11:0]) | f[13]);
         r = {s, 5'(e - SMALL_TO_F32_BIAS), f[22:13]};
         return r + {15'h0, up};
      end
      shift = F16_MIN_NORMAL_F32_EXP - e;
      if (e == 8'h0 || shift > F16_DENORM_SHIFT_MAX)
         return {s, 15'h0};
      wide = {1'b1, f, 26'h0} >> shift;
      up = wide[38] & ((|wide[37:0]) | wide[39]);
      r = {s, 5'h0, wide[48:39]};
      return r + {15'h0, up};
   endfunction

   function automatic cfc_class_t class_f32(input logic [31:0] x);
      if (x[30:23] == F32_EXP_MAX)
         return (x[22:0] != 23'h0) ? CLS_NAN : CLS_INF;
      return (x[30:0] == 31'h0) ? CLS_ZERO : CLS_FINITE;
   endfunction

   // common exponent channel: 0.f times 2^(e-15) = f times 2^(e-24)
   function automatic logic [31:0] shared_to_f32(input logic [8:0] m, input logic [4:0] e);
      logic [31:0] t;
      t = int_to_f32({23'h0, m}, 1'b0);
      if (m == 9'h0)
         return 32'h0;
      return {1'b0, t[30:23] + {3'h0, e} - SHARED_EXP_ADJ, t[22:0]};
   endfunction

   logic [63:0] pix;
   cfc_out_t conv;
   logic take;
   logic stage_valid_reg;
   logic stage_valid_next;
   cfc_out_t stage_data_reg;
   cfc_out_t stage_data_next;
   cfc_out_t buf_mem_reg [CFC_BUF_DEPTH];
   cfc_out_t buf_mem_next [CFC_BUF_DEPTH];
   logic buf_wr_ptr_reg;
   logic buf_wr_ptr_next;
   logic buf_rd_ptr_reg;
   logic buf_rd_ptr_next;
   logic [1:0] buf_count_reg;
   logic [1:0] buf_count_next;
   logic buf_push;
   logic buf_pop;

   assign pix = IN_DATA.bytes;

   // conversion datapath
   always_comb
   begin
      logic [31:0] field;
      logic [31:0] ext;
      logic [15:0] h;
      field = 32'h0;
      ext = 32'h0;
      h = 16'h0;
      conv = '0;
      unique case (IN_DATA.fmt)
         FMT_UNSIGNED_INTEGER_COPY, FMT_SIGNED_INTEGER_COPY,
         FMT_UNSIGNED_TO_FLOAT_SCALED, FMT_SIGNED_TO_FLOAT_SCALED:
         begin
            for (int i = 0; i < 4; i++)
            begin
               // 32-bit channels fill only two lanes of the 64-bit word
               unique case (IN_DATA.width)
                  WID_8:
                  begin
                     field = {24'h0, pix[i*8 +: 8]};
                     ext = {{24{field[7]}}, field[7:0]};
                  end
                  WID_16:
                  begin
                     field = {16'h0, pix[i*16 +: 16]};
                     ext = {{16{field[15]}}, field[15:0]};
                  end
                  default:
                  begin
                     field = (i < 2) ? pix[(i % 2)*32 +: 32] : 32'h0;
                     ext = field;
                  end
               endcase
               unique case (IN_DATA.fmt)
                  FMT_UNSIGNED_INTEGER_COPY: conv.ch[i] = field;
                  FMT_SIGNED_INTEGER_COPY: conv.ch[i] = ext;
                  FMT_UNSIGNED_TO_FLOAT_SCALED: conv.ch[i] = int_to_f32(field, 1'b0);
                  default: conv.ch[i] = int_to_f32(ext[31] ? (32'h0 - ext) : ext, ext[31]);
               endcase
               conv.cls[i] = (field == 32'h0) ? CLS_ZERO : CLS_FINITE;
            end
         end
         FMT_FLOAT32:
         begin
            for (int i = 0; i < 2; i++)
            begin
               conv.ch[i] = pix[i*32 +: 32];
               conv.cls[i] = class_f32(pix[i*32 +: 32]);
            end
            conv.cls[2] = CLS_ZERO;
            conv.cls[3] = CLS_ZERO;
         end
         FMT_FLOAT64:
         begin
            // raw word kept in lanes 0 and 1, its class in lanes 0 and 1
            conv.ch[0] = pix[31:0];
            conv.ch[1] = pix[63:32];
            if (pix[62:52] == F64_EXP_MAX)
            begin
               conv.cls[0] = (pix[51:0] != 52'h0) ? CLS_NAN : CLS_INF;
            end
            else
            begin
               conv.cls[0] = (pix[62:0] == 63'h0) ? CLS_ZERO : CLS_FINITE;
            end
            conv.cls[1] = conv.cls[0];
            conv.cls[2] = CLS_ZERO;
            conv.cls[3] = CLS_ZERO;
         end
         FMT_FLOAT16:
         begin
            for (int i = 0; i < 4; i++)
            begin
               h = pix[i*16 +: 16];
               conv.ch[i] = small_to_f32(h[15], h[14:10], h[9:0]);
               conv.cls[i] = class_f32(conv.ch[i]);
            end
         end
         FMT_FLOAT32_TO_FLOAT16:
         begin
            for (int i = 0; i < 2; i++)
            begin
               h = f32_to_f16(pix[i*32 +: 32]);
               conv.ch[i] = {16'h0, h};
               conv.cls[i] = class_f32(small_to_f32(h[15], h[14:10], h[9:0]));
            end
            conv.cls[2] = CLS_ZERO;
            conv.cls[3] = CLS_ZERO;
         end
         FMT_FLOAT11_11_10:
         begin
            conv.ch[0] = small_to_f32(1'b0, pix[10:6], {pix[5:0], 4'h0});
            conv.ch[1] = small_to_f32(1'b0, pix[21:17], {pix[16:11], 4'h0});
            conv.ch[2] = small_to_f32(1'b0, pix[31:27], {pix[26:22], 5'h0});
            conv.ch[3] = F32_ONE;
            for (int i = 0; i < 4; i++)
            begin
               conv.cls[i] = class_f32(conv.ch[i]);
            end
         end
         FMT_THREE_CHANNEL_COMMON_EXPONENT:
         begin
            conv.ch[0] = shared_to_f32(pix[8:0], pix[31:27]);
            conv.ch[1] = shared_to_f32(pix[17:9], pix[31:27]);
            conv.ch[2] = shared_to_f32(pix[26:18], pix[31:27]);
            conv.ch[3] = F32_ONE;
            for (int i = 0; i < 4; i++)
            begin
               // no infinity or NaN can come out of this format
               conv.cls[i] = (conv.ch[i] == 32'h0) ? CLS_ZERO : CLS_FINITE;
            end
         end
         FMT_INTENSITY_FLOAT32:
         begin
            if (IN_DATA.dest_write)
            begin
               conv.unsupported = 1'b1;
               for (int i = 0; i < 4; i++)
               begin
                  conv.cls[i] = CLS_ZERO;
               end
            end
            else
            begin
               for (int i = 0; i < 4; i++)
               begin
                  conv.ch[i] = pix[31:0];
                  conv.cls[i] = class_f32(pix[31:0]);
               end
            end
         end
         default: conv.unsupported = 1'b1;
      endcase
   end

   // one pipeline stage, then a two-entry buffer toward the receiver
   assign buf_push = stage_valid_reg && (buf_count_reg != CFC_BUF_DEPTH_W);
   assign buf_pop = OUT_VALID && OUT_READY;
   assign IN_READY = !stage_valid_reg || buf_push;
   assign take = IN_VALID && IN_READY;
   assign OUT_VALID = (buf_count_reg != 2'h0);
   assign OUT_DATA = buf_mem_reg[buf_rd_ptr_reg];

   always_comb
   begin
      stage_valid_next = stage_valid_reg;
      stage_data_next = stage_data_reg;
      if (take)
      begin
         stage_valid_next = 1'b1;
         stage_data_next = conv;
      end
      else if (buf_push)
      begin
         stage_valid_next = 1'b0;
      end
      buf_mem_next = buf_mem_reg;
      buf_wr_ptr_next = buf_wr_ptr_reg;
      buf_rd_ptr_next = buf_rd_ptr_reg;
      buf_count_next = buf_count_reg;
      if (buf_push)
      begin
         buf_mem_next[buf_wr_ptr_reg] = stage_data_reg;
         buf_wr_ptr_next = !buf_wr_ptr_reg;
      end
      if (buf_pop)
      begin
         buf_rd_ptr_next = !buf_rd_ptr_reg;
      end
      buf_count_next = buf_count_reg + {1'b0, buf_push} - {1'b0, buf_pop};
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         stage_valid_reg <= 1'b0;
         stage_data_reg <= '0;
         buf_mem_reg[0] <= '0;
         buf_mem_reg[1] <= '0;
         buf_wr_ptr_reg <= 1'b0;
         buf_rd_ptr_reg <= 1'b0;
         buf_count_reg <= 2'h0;
      end
      else
      begin
         stage_valid_reg <= stage_valid_next;
         stage_data_reg <= stage_data_next;
         buf_mem_reg <= buf_mem_next;
         buf_wr_ptr_reg <= buf_wr_ptr_next;
         buf_rd_ptr_reg <= buf_rd_ptr_next;
         buf_count_reg <= buf_count_next;
      end
   end

endmodule

// ===== hw/cfc_pkg.sv
// channel format converter shared types and constants
package cfc_pkg;
   typedef enum logic [3:0] {
      FMT_UNSIGNED_INTEGER_COPY,
      FMT_SIGNED_INTEGER_COPY,
      FMT_UNSIGNED_TO_FLOAT_SCALED,
      FMT_SIGNED_TO_FLOAT_SCALED,
      FMT_FLOAT32,
      FMT_FLOAT64,
      FMT_FLOAT16,
      FMT_FLOAT32_TO_FLOAT16,
      FMT_FLOAT11_11_10,
      FMT_THREE_CHANNEL_COMMON_EXPONENT,
      FMT_INTENSITY_FLOAT32
   } cfc_fmt_t;

   typedef enum logic [1:0] {
      WID_8,
      WID_16,
      WID_32
   } cfc_width_t;

   typedef enum logic [1:0] {
      CLS_FINITE,
      CLS_ZERO,
      CLS_INF,
      CLS_NAN
   } cfc_class_t;

   typedef struct packed {
      cfc_fmt_t fmt;
      cfc_width_t width;
      logic dest_write;
      logic [7:0][7:0] bytes;
   } cfc_in_t;

   typedef struct packed {
      logic unsupported;
      cfc_class_t [3:0] cls;
      logic [3:0][31:0] ch;
   } cfc_out_t;

   localparam int CFC_BUF_DEPTH = 2;
   localparam logic [1:0] CFC_BUF_DEPTH_W = 2'h2;
   localparam logic [7:0] F32_EXP_MAX = 8'hFF;
   localparam logic [7:0] F32_BIAS = 8'h7F;
   localparam logic [10:0] F64_EXP_MAX = 11'h7FF;
   localparam logic [4:0] SMALL_EXP_MAX = 5'h1F;
   localparam logic [7:0] SMALL_TO_F32_BIAS = 8'h70;
   localparam logic [7:0] SMALL_DENORM_ADJ = 8'h18;
   localparam logic [7:0] SHARED_EXP_ADJ = 8'h18;
   localparam logic [7:0] F16_MAX_UNBIASED = 8'h8E;
   localparam logic [7:0] F16_MIN_NORMAL_F32_EXP = 8'h71;
   localparam logic [7:0] F16_DENORM_SHIFT_MAX = 8'h19;
   localparam logic [31:0] F32_CANON_NAN = 32'h7FC00000;
   localparam logic [15:0] F16_CANON_NAN = 16'h7E00;
   localparam logic [31:0] F32_ONE = 32'h3F800000;
endpackage

// ===== testbench/cfc_converter_chk.sv
// port assertions for the channel format converter
`timescale 1ns/100ps
module cfc_converter_chk
   import cfc_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic IN_VALID,
   input wire logic IN_READY,
   input wire cfc_in_t IN_DATA,
   input wire logic OUT_VALID,
   input wire logic OUT_READY,
   input wire cfc_out_t OUT_DATA
);
   logic take_reg;
   logic lone;
   always_ff @(posedge REF_CLK)
   begin
      take_reg <= RST_N && IN_VALID && IN_READY;
   end
   // empty pipe, nothing in flight: this take is the next result out
   assign lone = IN_VALID && IN_READY && !OUT_VALID && !take_reg;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   property p_hold;
      OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved while stalled");
   property p_lat;
      IN_VALID && IN_READY |-> ##2 OUT_VALID;
   endproperty
   a_lat: assert property (p_lat) else $error("result late");
   property p_rise;
      $rose(OUT_VALID) |-> $past(IN_VALID && IN_READY, 2);
   endproperty
   a_rise: assert property (p_rise) else $error("result without take");
   property p_fell;
      $fell(OUT_VALID) |-> $past(OUT_READY);
   endproperty
   a_fell: assert property (p_fell) else $error("result dropped unread");
   property p_unsup;
      OUT_VALID && OUT_DATA.unsupported |-> OUT_DATA.ch == '0;
   endproperty
   a_unsup: assert property (p_unsup) else $error("refused word has data");
   property p_rep;
      lone && IN_DATA.fmt == FMT_INTENSITY_FLOAT32 && !IN_DATA.dest_write
         |-> ##2 OUT_DATA.ch[3] == $past(IN_DATA.bytes[3:0], 2) && OUT_DATA.ch[0] == OUT_DATA.ch[3];
   endproperty
   a_rep: assert property (p_rep) else $error("intensity not copied");
   property p_pos;
      lone && IN_DATA.fmt == FMT_THREE_CHANNEL_COMMON_EXPONENT
         |-> ##2 !(OUT_DATA.ch[0][31] || OUT_DATA.ch[1][31] || OUT_DATA.ch[2][31]);
   endproperty
   a_pos: assert property (p_pos) else $error("negative shared value");
   property p_sext;
      lone && IN_DATA.fmt == FMT_SIGNED_INTEGER_COPY && IN_DATA.width == WID_8
         |-> ##2 OUT_DATA.ch[0] == {{24{$past(IN_DATA.bytes[0][7], 2)}}, $past(IN_DATA.bytes[0], 2)};
   endproperty
   a_sext: assert property (p_sext) else $error("bad sign extension");
endmodule
bind cfc_converter cfc_converter_chk chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .IN_VALID(IN_VALID),
   .IN_READY(IN_READY), .IN_DATA(IN_DATA), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA));

// ===== testbench/cfc_sink.sv
// far-side receiver model: prompt, stalled, or every other cycle
`timescale 1ns/100ps
module cfc_sink
   import cfc_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic OUT_VALID,
   input wire cfc_out_t OUT_DATA,
   input wire logic stall,
   input wire logic slow,
   output logic OUT_READY
);
   cfc_out_t got[$];
   logic ph = 1'b0;
   logic rdy = 1'b0;
   assign OUT_READY = rdy;
   always @(posedge REF_CLK)
   begin
      if (OUT_VALID === 1'b1 && rdy)
         got.push_back(OUT_DATA);
      ph = !ph;
      #1 rdy = !stall && !(slow && ph);
   end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the channel format converter
`timescale 1ns/100ps
module tb
   import cfc_pkg::*;
;
   logic REF_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic IN_VALID = 1'b0;
   logic IN_READY;
   cfc_in_t IN_DATA = '0;
   logic OUT_VALID;
   logic OUT_READY;
   cfc_out_t OUT_DATA;
   logic stall = 1'b0;
   logic slow = 1'b0;
   int fails = 0;
   int n_tests = 0;
   int refused = 0;
   cfc_out_t q[8];
   always #20 REF_CLK = ~REF_CLK;
   cfc_converter dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
      .IN_DATA(IN_DATA), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA));
   cfc_sink sink (.REF_CLK(REF_CLK), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .stall(stall),
      .slow(slow), .OUT_READY(OUT_READY));
   always @(negedge REF_CLK)
      if (IN_VALID && IN_READY === 1'b0)
         refused++;
   task automatic send(input cfc_fmt_t f, input cfc_width_t w, input logic [63:0] px, input logic dw = 1'b0);
      logic ok;
      IN_DATA = '{fmt: f, width: w, dest_write: dw, bytes: px};
      IN_VALID = 1'b1;
      // ready is judged before the edge so the take edge is known
      do
      begin
         @(negedge REF_CLK);
         ok = (IN_READY === 1'b1);
         @(posedge REF_CLK);
      end
      while (!ok);
      #1;
   endtask
   task automatic collect(input int n);
      int i;
      i = 0;
      while (sink.got.size() < n && i < 200)
      begin
         @(posedge REF_CLK);
         i++;
      end
      #1;
      ck({31'h0, sink.got.size() >= n}, 32'h1);
      for (int k = 0; k < n; k++)
         q[k] = (k < sink.got.size()) ? sink.got[k] : '0;
      sink.got.delete();
   endtask
   task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic t_lat();
      send(FMT_INTENSITY_FLOAT32, WID_32, 64'h00000000_40490FDB);
      IN_VALID = 1'b0;
      @(negedge REF_CLK);
      ck({31'h0, OUT_VALID}, 32'h0);
      @(negedge REF_CLK);
      ck({31'h0, OUT_VALID}, 32'h1);
      @(posedge REF_CLK);
      #1;
      send(FMT_INTENSITY_FLOAT32, WID_32, 64'h00000000_40490FDB, 1'b1);
      IN_VALID = 1'b0;
      collect(2);
      for (int i = 0; i < 4; i++)
         ck(q[0].ch[i], 32'h40490FDB);
      ck({31'h0, q[1].unsupported}, 32'h1);
      ck(q[1].ch[0], 32'h0);
      $display("end t_lat");
   endtask
   task automatic t_int();
      send(FMT_SIGNED_INTEGER_COPY, WID_8, 64'h00000000_7F80FD01);
      send(FMT_UNSIGNED_INTEGER_COPY, WID_8, 64'h00000000_FF030201);
      send(FMT_SIGNED_TO_FLOAT_SCALED, WID_16, 64'h00000000_0000FFFD);
      send(FMT_UNSIGNED_TO_FLOAT_SCALED, WID_32, 64'hFEFFFFFF_01000001);
      send(FMT_SIGNED_TO_FLOAT_SCALED, WID_32, 64'h00000003_FEFFFFFF);
      IN_VALID = 1'b0;
      collect(5);
      ck(q[0].ch[1], 32'hFFFFFFFD);
      ck(q[0].ch[3], 32'h0000007F);
      ck(q[1].ch[0], 32'h00000001);
      ck(q[1].ch[2], 32'h00000003);
      ck(q[1].ch[3], 32'h000000FF);
      ck(q[2].ch[0], 32'hC0400000);
      ck(32'(q[2].cls[1]), 32'h1);
      ck(q[3].ch[0], 32'h4B800000);
      ck(q[3].ch[1], 32'h4F7F0000);
      ck(q[4].ch[0], 32'hCB800000);
      $display("end t_int");
   endtask
   task automatic t_float();
      send(FMT_FLOAT32, WID_32, 64'hFF800000_7F800001);
      send(FMT_FLOAT64, WID_32, 64'h3FF00000_00000000);
      send(FMT_FLOAT16, WID_16, 64'h0001_7C01_FC00_3C00);
      send(FMT_FLOAT32_TO_FLOAT16, WID_32, 64'h3F803000_3F801000);
      send(FMT_FLOAT32_TO_FLOAT16, WID_32, 64'h47800000_BF800000);
      IN_VALID = 1'b0;
      collect(5);
      ck(q[0].ch[0], 32'h7F800001);
      ck(32'(q[0].cls[0]), 32'h3);
      ck(32'(q[0].cls[1]), 32'h2);
      ck(q[1].ch[1], 32'h3FF00000);
      ck(32'(q[1].cls[0]), 32'h0);
      ck(q[2].ch[1], 32'hFF800000);
      ck(q[2].ch[2], 32'h7FC00000);
      ck(q[2].ch[3], 32'h33800000);
      ck(q[3].ch[0], 32'h00003C00);
      ck(q[3].ch[1], 32'h00003C02);
      ck(q[4].ch[0], 32'h0000BC00);
      ck(q[4].ch[1], 32'h00007C00);
      $display("end t_float");
   endtask
   task automatic t_pack();
      send(FMT_THREE_CHANNEL_COMMON_EXPONENT, WID_32, 64'h00000000_80050100);
      send(FMT_FLOAT11_11_10, WID_32, 64'h00000000_F87E03C0);
      send(FMT_FLOAT11_11_10, WID_32, 64'h00000000_00000001);
      send(cfc_fmt_t'(4'hB), WID_32, 64'hFFFFFFFF_FFFFFFFF);
      IN_VALID = 1'b0;
      collect(4);
      ck(q[0].ch[0], 32'h3F800000);
      ck(q[0].ch[1], 32'h3F000000);
      ck(q[0].ch[2], 32'h3B800000);
      ck(q[1].ch[0], 32'h3F800000);
      ck(q[1].ch[1], 32'h7F800000);
      ck(q[1].ch[2], 32'h7FC00000);
      ck(q[2].ch[0], 32'h35800000);
      ck({31'h0, q[3].unsupported}, 32'h1);
      $display("end t_pack");
   endtask
   task automatic t_stall();
      int base;
      base = refused;
      stall = 1'b1;
      fork
         begin
            repeat (20) @(posedge REF_CLK);
            #1 stall = 1'b0;
            slow = 1'b1;
         end
      join_none
      for (int i = 0; i < 6; i++)
         send(FMT_UNSIGNED_INTEGER_COPY, WID_32, {32'h0, 32'(i)});
      IN_VALID = 1'b0;
      ck({31'h0, refused != base}, 32'h1);
      collect(6);
      for (int i = 0; i < 6; i++)
         ck(q[i].ch[0], 32'(i));
      ck({31'h0, OUT_VALID}, 32'h0);
      slow = 1'b0;
      $display("end t_stall");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge REF_CLK);
      #1 RST_N = 1'b1;
      t_lat();
      t_int();
      t_float();
      t_pack();
      t_stall();
      report_and_stop();
   end
   // run needs well under a thousand cycles
   initial
   begin
      #160000;
      fails++;
      report_and_stop();
   end
endmodule
